// ### hdl/tcc_pkg.sv
// Purpose: Shared constants and types for the 16-bit capture timer
// Assumes: 8-bit register port, byte offsets below
// Notes: All offsets and field positions live here, with the control, count and capture reset values
package tcc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] TCC_OFF_CTRL = 3'h0;
  localparam logic [2:0] TCC_OFF_CNT_LO = 3'h1;
  localparam logic [2:0] TCC_OFF_CNT_HI = 3'h2;
  localparam logic [2:0] TCC_OFF_CAP_LO = 3'h3;
  localparam logic [2:0] TCC_OFF_CAP_HI = 3'h4;
  localparam logic [2:0] TCC_OFF_MASK = 3'h5;
  localparam logic [2:0] TCC_OFF_FLAGS = 3'h6;
  localparam logic [2:0] TCC_OFF_AUX = 3'h7;

  // ==========================================================
  // Field positions
  localparam int TCC_MASK_CAP_BIT = 5;
  localparam int TCC_MASK_OVF_BIT = 0;
  localparam int TCC_FLAG_CAP_BIT = 5;
  localparam int TCC_FLAG_OVF_BIT = 0;
  localparam int TCC_AUX_CMP_BIT = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] TCC_CTRL_RESET = 8'h00;
  localparam logic [15:0] TCC_CNT_RESET = 16'h0000;
  localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
  localparam logic [15:0] TCC_CAP_RESET = 16'h0000;
  localparam int TCC_FILTER_SAMPLES = 4;

  // ==========================================================
  // Clock source codes
  typedef enum logic [2:0] {
    TCC_CS_STOP = 3'b000,
    TCC_CS_SYS = 3'b001,
    TCC_CS_EXT_FALL = 3'b110,
    TCC_CS_EXT_RISE = 3'b111
  } tcc_clksel_type;

  // ==========================================================
  // Control register layout
  typedef struct packed {
    logic filterEnable;
    logic edgeRising;
    logic rsv5;
    logic clearOnMatch;
    logic rsv3;
    logic [2:0] clockSource;
  } tcc_ctrl_type;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } tcc_bus_type;

endpackage

// ### hdl/tcc_timer16.sv
// Purpose: 16-bit up counter with normal and clear-on-match modes and input capture
// Assumes: 50 MHz clk, synchronous active-low reset, pins asynchronous
// Notes: Notes on behaviour below
// Notes on behaviour
// R01 - Normal mode counts up forever, wrapping 0xFFFF to 0x0000.
// R02 - Normal mode sets overflow flag as count becomes zero; counting never clears it.
// R03 - Normal mode accepts counter writes anytime with no special handling.
// R04 - Clear-on-match mode clears counter when it equals the top register.
// R05 - Top register unbuffered; written below count, counter wraps through 0xFFFF first.
// R06 - Clear-on-match mode sets capture flag on each top match.
// R07 - Clear-on-match mode sets overflow flag when passing 0xFFFF to 0x0000.
// R08 - Filter enable bit 7 needs four equal samples, delaying capture four cycles.
// R09 - Edge select bit 6: zero falling, one rising capture edge.
// R10 - Capture edge copies counter to capture register and sets capture flag.
// R11 - Capture source is the pin or optionally the comparator output.
// R12 - In clear-on-match mode the capture input is disconnected.
// R13 - Clock select 000 stop, 001 system clock, 110/111 external falling/rising.
// R14 - External count pin clocks the counter regardless of its pin direction.
// R15 - Sixteen-bit registers move through one shared high-byte latch.
// R16 - Counter write suppresses compare match on the next timer tick.
// R17 - Mask bit 5 capture enable, bit 0 overflow enable; bits 7,6 read zero.
// R18 - Overflow flag clears on its vector or by writing one.
// R19 - Capture flag clears on its vector or by writing one.
// R20 - Counter write beats any clear or count in the same cycle.
// R21 - Interrupt requested only with global enable, mask bit and flag set.
// R22 - Capture and count inputs are synchronised before edge detection.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer16 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  // Event pins and comparator
  input wire logic capturePin,
  input wire logic countPin,
  input wire logic comparatorOut,
  // Interrupt handshake
  input wire logic globalIrqEnable,
  input wire logic overflowVectorAck,
  input wire logic captureVectorAck,
  output logic overflowIrq,
  output logic captureIrq
);

  // ==========================================================
  // Request bundle
  tcc_pkg::tcc_bus_type bus;
  assign bus = '{addr: regAddr, wrData: regWrData, wrStrobe: regWrStrobe,
                 rdStrobe: regRdStrobe};

  // ==========================================================
  // Input synchronisers
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;

  // Two flops per asynchronous input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
    end else begin
      syncA_reg <= {comparatorOut, countPin, capturePin}; // R22
      syncB_reg <= syncA_reg; // R22
    end
  end

  // ==========================================================
  // State
  tcc_pkg::tcc_ctrl_type ctrl_reg, ctrl_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] capture_reg, capture_next;
  logic [7:0] temp_reg, temp_next;
  logic capIrqEn_reg, capIrqEn_next;
  logic ovfIrqEn_reg, ovfIrqEn_next;
  logic compSel_reg, compSel_next;
  logic ovfFlag_reg, ovfFlag_next;
  logic capFlag_reg, capFlag_next;
  logic blockMatch_reg, blockMatch_next;
  logic [3:0] filterHist_reg, filterHist_next;
  logic filterLevel_reg, filterLevel_next;
  logic capPrev_reg, capPrev_next;
  logic cntPinPrev_reg, cntPinPrev_next;
  logic [7:0] rdData_reg, rdData_next;
  logic ovfIrq_reg, ovfIrq_next;
  logic capIrq_reg, capIrq_next;

  // Decoded helpers
  logic capSource;
  logic capLevel;
  logic capEdge;
  logic tick;
  logic writeCount;
  logic topMatch;
  logic ovfEvent;
  logic capEvent;
  logic [7:0] flagWord;
  logic [7:0] maskWord;

  // ==========================================================
  // Capture path: source, filter and edge
  always_comb begin
    capSource = compSel_reg ? syncB_reg[2] : syncB_reg[0]; // R11
    filterHist_next = {filterHist_reg[2:0], capSource};
    filterLevel_next = filterLevel_reg;
    // Three stored samples plus the current one, so the filter adds four cycles, not five
    if (filterHist_next == 4'hf) begin
      filterLevel_next = 1'b1; // R08
    end else if (filterHist_next == 4'h0) begin
      filterLevel_next = 1'b0; // R08
    end
    capLevel = ctrl_reg.filterEnable ? filterLevel_reg : capSource; // R08
    capPrev_next = capLevel;
    if (ctrl_reg.edgeRising) begin
      capEdge = capLevel && !capPrev_reg; // R09
    end else begin
      capEdge = !capLevel && capPrev_reg; // R09
    end
  end

  // ==========================================================
  // Timer clock enable
  always_comb begin
    cntPinPrev_next = syncB_reg[1]; // R14
    case (tcc_pkg::tcc_clksel_type'(ctrl_reg.clockSource))
      tcc_pkg::TCC_CS_SYS: begin
        tick = 1'b1; // R13
      end
      tcc_pkg::TCC_CS_EXT_FALL: begin
        tick = cntPinPrev_reg && !syncB_reg[1]; // R13
      end
      tcc_pkg::TCC_CS_EXT_RISE: begin
        tick = !cntPinPrev_reg && syncB_reg[1]; // R13
      end
      default: begin
        tick = 1'b0; // R13
      end
    endcase
  end

  // ==========================================================
  // Counter, capture register and flags
  always_comb begin
    writeCount = bus.wrStrobe && (bus.addr == tcc_pkg::TCC_OFF_CNT_LO);
    // Top compare is plain equality, so a low top is missed until wrap
    topMatch = ctrl_reg.clearOnMatch && (count_reg == capture_reg) && !blockMatch_reg; // R05
    ovfEvent = 1'b0;
    capEvent = 1'b0;
    count_next = count_reg;
    blockMatch_next = blockMatch_reg;
    capture_next = capture_reg;
    if (writeCount) begin
      count_next = {temp_reg, bus.wrData}; // R20 R03 R15
      blockMatch_next = 1'b1; // R16
    end else if (tick) begin
      blockMatch_next = 1'b0; // R16
      if (topMatch) begin
        count_next = tcc_pkg::TCC_CNT_RESET; // R04
        capEvent = 1'b1; // R06
      end else begin
        count_next = count_reg + 16'h0001; // R01
      end
      if (count_reg == tcc_pkg::TCC_CNT_MAX) begin
        ovfEvent = 1'b1; // R02 R07
      end
    end
    // Capture only while the capture register is not the top
    if (!ctrl_reg.clearOnMatch && capEdge) begin
      capture_next = count_reg; // R10 R12
      capEvent = 1'b1; // R10
    end else if (ctrl_reg.clearOnMatch && bus.wrStrobe &&
                 bus.addr == tcc_pkg::TCC_OFF_CAP_LO) begin
      capture_next = {temp_reg, bus.wrData}; // R15
    end
    // Set wins over clear
    ovfFlag_next = ovfFlag_reg;
    if (overflowVectorAck || (bus.wrStrobe && bus.addr == tcc_pkg::TCC_OFF_FLAGS &&
        bus.wrData[tcc_pkg::TCC_FLAG_OVF_BIT])) begin
      ovfFlag_next = 1'b0; // R18
    end
    if (ovfEvent) begin
      ovfFlag_next = 1'b1; // R02
    end
    capFlag_next = capFlag_reg;
    if (captureVectorAck || (bus.wrStrobe && bus.addr == tcc_pkg::TCC_OFF_FLAGS &&
        bus.wrData[tcc_pkg::TCC_FLAG_CAP_BIT])) begin
      capFlag_next = 1'b0; // R19
    end
    if (capEvent) begin
      capFlag_next = 1'b1; // R06 R10
    end
    ovfIrq_next = globalIrqEnable && ovfIrqEn_reg && ovfFlag_reg; // R21
    capIrq_next = globalIrqEnable && capIrqEn_reg && capFlag_reg; // R21
  end

  // ==========================================================
  // Register port: writes, reads and high-byte latch
  always_comb begin
    flagWord = 8'h00;
    flagWord[tcc_pkg::TCC_FLAG_CAP_BIT] = capFlag_reg;
    flagWord[tcc_pkg::TCC_FLAG_OVF_BIT] = ovfFlag_reg;
    maskWord = 8'h00; // R17
    maskWord[tcc_pkg::TCC_MASK_CAP_BIT] = capIrqEn_reg;
    maskWord[tcc_pkg::TCC_MASK_OVF_BIT] = ovfIrqEn_reg;
    ctrl_next = ctrl_reg;
    capIrqEn_next = capIrqEn_reg;
    ovfIrqEn_next = ovfIrqEn_reg;
    compSel_next = compSel_reg;
    temp_next = temp_reg;
    rdData_next = 8'h00;
    if (bus.wrStrobe) begin
      case (bus.addr)
        tcc_pkg::TCC_OFF_CTRL: begin
          ctrl_next = tcc_pkg::tcc_ctrl_type'(bus.wrData);
          ctrl_next.rsv5 = 1'b0;
          ctrl_next.rsv3 = 1'b0;
        end
        tcc_pkg::TCC_OFF_CNT_HI, tcc_pkg::TCC_OFF_CAP_HI: begin
          temp_next = bus.wrData; // R15
        end
        tcc_pkg::TCC_OFF_MASK: begin
          capIrqEn_next = bus.wrData[tcc_pkg::TCC_MASK_CAP_BIT]; // R17
          ovfIrqEn_next = bus.wrData[tcc_pkg::TCC_MASK_OVF_BIT]; // R17
        end
        tcc_pkg::TCC_OFF_AUX: begin
          compSel_next = bus.wrData[tcc_pkg::TCC_AUX_CMP_BIT]; // R11
        end
        default: begin
          temp_next = temp_reg;
        end
      endcase
    end else if (bus.rdStrobe) begin
      case (bus.addr)
        tcc_pkg::TCC_OFF_CTRL: begin
          rdData_next = ctrl_reg;
        end
        tcc_pkg::TCC_OFF_CNT_LO: begin
          rdData_next = count_reg[7:0];
          temp_next = count_reg[15:8]; // R15
        end
        tcc_pkg::TCC_OFF_CAP_LO: begin
          rdData_next = capture_reg[7:0];
          temp_next = capture_reg[15:8]; // R15
        end
        tcc_pkg::TCC_OFF_CNT_HI, tcc_pkg::TCC_OFF_CAP_HI: begin
          rdData_next = temp_reg; // R15
        end
        tcc_pkg::TCC_OFF_MASK: begin
          rdData_next = maskWord; // R17
        end
        tcc_pkg::TCC_OFF_FLAGS: begin
          rdData_next = flagWord;
        end
        default: begin
          rdData_next = {7'h00, compSel_reg};
        end
      endcase
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= tcc_pkg::tcc_ctrl_type'(tcc_pkg::TCC_CTRL_RESET);
      count_reg <= tcc_pkg::TCC_CNT_RESET;
      capture_reg <= tcc_pkg::TCC_CAP_RESET;
      temp_reg <= 8'h00;
      capIrqEn_reg <= 1'b0;
      ovfIrqEn_reg <= 1'b0;
      compSel_reg <= 1'b0;
      ovfFlag_reg <= 1'b0;
      capFlag_reg <= 1'b0;
      blockMatch_reg <= 1'b0;
      filterHist_reg <= 4'h0;
      filterLevel_reg <= 1'b0;
      capPrev_reg <= 1'b0;
      cntPinPrev_reg <= 1'b0;
      rdData_reg <= 8'h00;
      ovfIrq_reg <= 1'b0;
      capIrq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      capture_reg <= capture_next;
      temp_reg <= temp_next;
      capIrqEn_reg <= capIrqEn_next;
      ovfIrqEn_reg <= ovfIrqEn_next;
      compSel_reg <= compSel_next;
      ovfFlag_reg <= ovfFlag_next;
      capFlag_reg <= capFlag_next;
      blockMatch_reg <= blockMatch_next;
      filterHist_reg <= filterHist_next;
      filterLevel_reg <= filterLevel_next;
      capPrev_reg <= capPrev_next;
      cntPinPrev_reg <= cntPinPrev_next;
      rdData_reg <= rdData_next;
      ovfIrq_reg <= ovfIrq_next;
      capIrq_reg <= capIrq_next;
    end
  end

  // Outputs straight from flops
  assign regRdData = rdData_reg;
  assign overflowIrq = ovfIrq_reg;
  assign captureIrq = capIrq_reg;

endmodule

`default_nettype wire

// ### sim/tcc_pin_model.sv
// Purpose: Far-side model of the capture, count and comparator pins
// Assumes: Bench requests levels on pinWant; slow adds one cycle of lag
// Notes: Pins move on the falling edge, unrelated to the design's sampling edge
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // Clock
  input wire logic clk,
  // Requests: 2 capture, 1 count, 0 comparator
  input wire logic [2:0] pinWant,
  input wire logic slow,
  // Pins
  output logic capturePin,
  output logic countPin,
  output logic comparatorOut
);
  logic [2:0] stageA = 3'h0;
  logic [2:0] stageB = 3'h0;
  // Request pipeline for prompt or slow answers
  always @(posedge clk) begin
    stageA <= pinWant;
    stageB <= stageA;
  end
  // Pins idle low at time zero
  initial {capturePin, countPin, comparatorOut} = 3'h0;
  // Off-edge pin changes, so the design must synchronise
  always @(negedge clk) begin
    {capturePin, countPin, comparatorOut} <= slow ? stageB : stageA;
  end
endmodule
`default_nettype wire

// ### sim/tcc_timer16_assertions.sv
// Purpose: Port checks for the capture timer
// Assumes: One clock, synchronous active-low reset
// Notes: Shadows the irq mask from port writes
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [7:0] regRdData,
  // Interrupt side
  input wire logic globalIrqEnable,
  input wire logic overflowIrq,
  input wire logic captureIrq
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ========
  // Mask shadow
  logic [1:0] maskReg;
  logic [1:0] maskNext;
  // Next mask from port writes
  always_comb begin
    maskNext = maskReg;
    if (regWrStrobe && regAddr == tcc_pkg::TCC_OFF_MASK) begin
      maskNext = {regWrData[5], regWrData[0]};
    end
  end
  // Mask register
  always_ff @(posedge clk) begin
    maskReg <= rst_b ? maskNext : 2'h0;
  end
  // Reserved bits read back zero
  property rsvZero(logic [2:0] a, logic [7:0] m);
    $past(regRdStrobe && regAddr == a) |-> (regRdData & m) == 8'h00;
  endproperty
  // ========
  // Assertions
  rd_idle_zero_a: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
    else $error("read data not idle");
  mask_rsv_zero_a: assert property (rsvZero(tcc_pkg::TCC_OFF_MASK, 8'hde))
    else $error("mask reserved bits set");
  ctrl_rsv_zero_a: assert property (rsvZero(tcc_pkg::TCC_OFF_CTRL, 8'h28))
    else $error("control reserved bits set");
  flag_rsv_zero_a: assert property (rsvZero(tcc_pkg::TCC_OFF_FLAGS, 8'hde))
    else $error("flag reserved bits set");
  ovf_glob_gate_a: assert property ($past(!globalIrqEnable) |-> !overflowIrq)
    else $error("overflow irq without global enable");
  cap_glob_gate_a: assert property ($past(!globalIrqEnable) |-> !captureIrq)
    else $error("capture irq without global enable");
  ovf_mask_gate_a: assert property (!$past(maskReg[0]) |-> !overflowIrq)
    else $error("overflow irq while masked");
  cap_mask_gate_a: assert property (!$past(maskReg[1]) |-> !captureIrq)
    else $error("capture irq while masked");
  // Main scenarios
  cover property ($rose(overflowIrq));
  cover property ($rose(captureIrq));
  cover property (regRdStrobe ##1 regWrStrobe);
endmodule
bind tcc_timer16 tcc_timer16_assertions u_chk (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
  .regRdData(regRdData), .globalIrqEnable(globalIrqEnable), .overflowIrq(overflowIrq),
  .captureIrq(captureIrq));
`default_nettype wire

// ### sim/tcc_timer16_tb_top.sv
// Purpose: Self-checking bench for the capture timer
// Assumes: 50 MHz clock, pin model on the event pins
// Notes: Random starts and counts from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0, regRdStrobe = 1'b0, globalIrqEnable = 1'b0;
  logic overflowVectorAck = 1'b0, captureVectorAck = 1'b0, slowPins = 1'b0;
  logic [2:0] pinWant = 3'h0;
  logic [7:0] regRdData, rdb;
  logic capturePin, countPin, comparatorOut, overflowIrq, captureIrq;
  logic [15:0] val, v16, top;
  logic [17:0] res;
  int fails = 0;
  int n_checks = 0;
  int n, seedVal;
  // Clock
  initial begin
    forever #10 clk = ~clk;
  end
  // Design and pins
  tcc_timer16 uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .capturePin(capturePin), .countPin(countPin), .comparatorOut(comparatorOut),
    .globalIrqEnable(globalIrqEnable), .overflowVectorAck(overflowVectorAck),
    .captureVectorAck(captureVectorAck), .overflowIrq(overflowIrq), .captureIrq(captureIrq));
  tcc_pin_model pins (.clk(clk), .pinWant(pinWant), .slow(slowPins), .capturePin(capturePin),
    .countPin(countPin), .comparatorOut(comparatorOut));
  // ========
  // Bus and pin tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData;
  endtask
  // High byte into the latch first, low byte commits
  task automatic wr16(input logic [2:0] lo, input logic [15:0] d);
    wr(lo + 3'h1, d[15:8]);
    wr(lo, d[7:0]);
  endtask
  task automatic rd16(input logic [2:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 3'h1, d[15:8]);
  endtask
  task automatic setPin(input int idx, input logic lvl, input int w);
    @(posedge clk);
    pinWant[idx] <= lvl;
    repeat (w) @(posedge clk);
  endtask
  // Expected {match, overflow, count} after k ticks following a count write
  function automatic logic [17:0] afterTicks(input logic [15:0] s, input logic [15:0] t,
    input logic clear_on_match_mode, input int k);
    logic [17:0] r;
    r = {2'b00, s};
    for (int i = 0; i < k; i++) begin
      r[16] = r[16] | (r[15:0] == 16'hffff);
      if (clear_on_match_mode && i > 0 && r[15:0] == t) begin
        r[17] = 1'b1;
        r[15:0] = 16'h0000;
      end else begin
        r[15:0] = r[15:0] + 16'h0001;
      end
    end
    return r;
  endfunction
  // Verdict
  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  // ========
  // Main sequence
  initial begin
    seedVal = $urandom(32'h2f06);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd16(tcc_pkg::TCC_OFF_CNT_LO, v16);
    chk("count reset", v16, tcc_pkg::TCC_CNT_RESET);
    rd(tcc_pkg::TCC_OFF_CTRL, rdb);
    chk("ctrl reset", rdb, tcc_pkg::TCC_CTRL_RESET);
    rd(tcc_pkg::TCC_OFF_MASK, rdb);
    chk("mask reset", rdb, 16'h0000);
    // Every clock code but the free-running one, counted on the pin
    for (int cs = 0; cs < 8; cs++) begin
      if (cs != 1) begin
        val = 16'hfffd + 16'($urandom % 4);
        n = 1 + $urandom % 5;
        slowPins <= 1'($urandom);
        wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
        wr16(tcc_pkg::TCC_OFF_CNT_LO, val);
        wr(tcc_pkg::TCC_OFF_CTRL, 8'(cs));
        repeat (n) begin
          setPin(1, 1'b1, 6);
          setPin(1, 1'b0, 6);
        end
        wr(tcc_pkg::TCC_OFF_CTRL, 8'h00);
        rd16(tcc_pkg::TCC_OFF_CNT_LO, v16);
        res = (cs >= 6) ? afterTicks(val, 16'h0000, 1'b0, n) : {2'b00, val};
        chk("pin count", v16, res[15:0]);
        rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
        chk("overflow flag", rdb[0], res[16]);
      end
    end
    // Clear on match: from zero, from top, from above top
    top = 16'h0003 + 16'($urandom % 4);
    wr(tcc_pkg::TCC_OFF_CTRL, 8'h10);
    wr16(tcc_pkg::TCC_OFF_CAP_LO, top);
    for (int i = 0; i < 3; i++) begin
      val = (i == 0) ? 16'h0000 : top + 16'(i - 1);
      n = 2 * int'(top) + 3;
      wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
      wr16(tcc_pkg::TCC_OFF_CNT_LO, val);
      wr(tcc_pkg::TCC_OFF_CTRL, 8'h17);
      repeat (n) begin
        setPin(1, 1'b1, 6);
        setPin(1, 1'b0, 6);
      end
      wr(tcc_pkg::TCC_OFF_CTRL, 8'h10);
      rd16(tcc_pkg::TCC_OFF_CNT_LO, v16);
      res = afterTicks(val, top, 1'b1, n);
      chk("match count", v16, res[15:0]);
      rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
      chk("match flag", rdb[5], res[17]);
    end
    // Capture pin has no effect while the register is the top
    wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
    setPin(2, 1'b1, 12);
    setPin(2, 1'b0, 12);
    rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
    chk("top mode flag", rdb[5], 1'b0);
    rd16(tcc_pkg::TCC_OFF_CAP_LO, v16);
    chk("top kept", v16, top);
    // Edge select and filter table, with a three-cycle glitch first
    for (int k = 0; k < 4; k++) begin
      val = 16'($urandom);
      wr(tcc_pkg::TCC_OFF_CTRL, 8'(k << 6));
      wr16(tcc_pkg::TCC_OFF_CNT_LO, val);
      repeat (8) @(posedge clk);
      wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
      setPin(2, 1'b1, 2);
      setPin(2, 1'b0, 12);
      rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
      chk("glitch capture", rdb[5], !k[1]);
      wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
      setPin(2, 1'b1, 12);
      rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
      chk("rising capture", rdb[5], k[0]);
      setPin(2, 1'b0, 12);
      rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
      chk("edge capture", rdb[5], 1'b1);
      rd16(tcc_pkg::TCC_OFF_CAP_LO, v16);
      chk("capture value", v16, val);
    end
    // Comparator as capture source
    wr(tcc_pkg::TCC_OFF_AUX, 8'h01);
    repeat (8) @(posedge clk);
    wr(tcc_pkg::TCC_OFF_FLAGS, 8'h21);
    setPin(0, 1'b1, 12);
    setPin(0, 1'b0, 12);
    rd(tcc_pkg::TCC_OFF_FLAGS, rdb);
    chk("comparator capture", rdb[5], 1'b1);
    // Interrupts: raise, acknowledge, write-one clear
    wr16(tcc_pkg::TCC_OFF_CNT_LO, 16'hffff);
    wr(tcc_pkg::TCC_OFF_CTRL, 8'h07);
    setPin(1, 1'b1, 6);
    setPin(1, 1'b0, 8);
    globalIrqEnable <= 1'b1;
    wr(tcc_pkg::TCC_OFF_MASK, 8'hff);
    rd(tcc_pkg::TCC_OFF_MASK, rdb);
    chk("mask bits", rdb, 16'h0021);
    #1;
    chk("overflow irq", overflowIrq, 1'b1);
    chk("capture irq", captureIrq, 1'b1);
    @(posedge clk);
    captureVectorAck <= 1'b1;
    @(posedge clk);
    captureVectorAck <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("capture irq ack", captureIrq, 1'b0);
    chk("overflow irq held", overflowIrq, 1'b1);
    wr(tcc_pkg::TCC_OFF_FLAGS, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk("overflow irq clear", overflowIrq, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
